// ===== bench/schc_assertions.sv
// Concurrent checks on the ports of the control slice.
`default_nettype none
module schc_assertions
  import schc_pkg::*;
#(
  parameter int ACT_TICKS = 50
) (
  // Clock and register port
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [schc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [schc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [schc_pkg::DATA_W-1:0] reg_rdata,
  // Pins
  input wire logic line_sync_pin,
  input wire logic frame_sync_pin,
  input wire logic clamp_pin,
  input wire logic holdover_pin,
  // Outputs
  input wire schc_pkg::schc_sync_out_t sync_out,
  input wire schc_pkg::schc_oe_t out_en,
  input wire schc_pkg::schc_analog_cfg_t analog_cfg,
  input wire logic chip_sleep_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Shadow registers
  // ****************************************************************
  logic [7:0] sc;
  logic [7:0] cc;
  logic [1:0] live;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sc <= 8'h40;
      cc <= 8'h4A;
      live <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == ADDR_SYNC_CTRL)
        sc <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CLAMP_CTRL)
        cc <= reg_wdata;
      if (live != 2'h3)
        live <= live + 2'h1;
    end
  end
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_SLEEP: assert property (s_wr(ADDR_CLAMP_CTRL) |->
    ##2 chip_sleep_n == $past(reg_wdata[1], 2)) else $error("sleep bit lost");
  AST_SLEEP_OE: assert property (s_wr(ADDR_CLAMP_CTRL) ##0 !reg_wdata[1] |->
    ##2 out_en == 3'h0) else $error("outputs driven in power down");
  AST_TRIM: assert property (s_wr(ADDR_RED_TRIM) |->
    ##2 analog_cfg.red_trim == $past(reg_wdata[7:1], 2)) else $error("trim code wrong");
  AST_DARKEN: assert property (s_wr(ADDR_BLUE_TRIM) |-> ##2
    analog_cfg.darken[0] == ($past(reg_wdata[7:1], 2) > 7'h10)) else $error("darken wrong");
  AST_SLICER: assert property (s_wr(ADDR_SLICER) |->
    ##2 analog_cfg.slicer_code == $past(reg_wdata[7:3], 2)) else $error("slicer code wrong");
  AST_LINE: assert property (live == 2'h3 && $past(sc[7]) && $past(sc[4])
    && !$past(sc[3]) && out_en.sync_oe |-> sync_out.line_sync_output ==
    (($past(line_sync_pin, 2) == $past(sc[6])) ^ $past(sc[5]))) else $error("line sync wrong");
  AST_FRAME: assert property (live == 2'h3 && $past(sc[1]) && !$past(sc[0])
    && out_en.sync_oe |-> sync_out.frame_sync_output ==
    ($past(frame_sync_pin, 2) ^ !$past(sc[2]))) else $error("frame sync wrong");
  AST_CLAMP: assert property (live == 2'h3 && $past(cc[7]) |->
    sync_out.clamp_active == ($past(clamp_pin) ^ $past(cc[6]))) else $error("clamp wrong");
  AST_HOLD: assert property (live == 2'h3 && !$past(cc[5]) && $past(cc[4]) |->
    sync_out.holdover_active == ($past(holdover_pin, 2) == $past(cc[3])))
    else $error("holdover wrong");
endmodule
bind schc_top schc_assertions #(.ACT_TICKS(ACT_TICKS)) i_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_sync_pin(line_sync_pin),
  .frame_sync_pin(frame_sync_pin), .clamp_pin(clamp_pin), .holdover_pin(holdover_pin),
  .sync_out(sync_out), .out_en(out_en), .analog_cfg(analog_cfg), .chip_sleep_n(chip_sleep_n));
`default_nettype wire

// ===== bench/schc_video_src.sv
// Behavioural video source driving the sync and control pins.
`default_nettype none
module schc_video_src (
  // Clock and controls
  input wire logic clk_sys,
  input wire logic line_en,
  input wire logic frame_en,
  input wire logic green_en,
  input wire logic line_high,
  // Pins
  output logic line_sync_pin,
  output logic frame_sync_pin,
  output logic green_embedded_sync_input,
  output logic clamp_pin,
  output logic holdover_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] pix = 9'h000;
  wire logic lp = pix[5:0] < 6'h08;
  wire logic fp = pix[8:6] < 3'h2;
  always @(posedge clk_sys)
    pix <= pix + 9'h001;
  // Disabled pins rest inactive, so the activity monitors can time out.
  assign line_sync_pin = line_en ? lp ~^ line_high : !line_high;
  assign frame_sync_pin = frame_en & fp;
  assign green_embedded_sync_input = !(green_en & (lp ^ fp));
  assign clamp_pin = pix[4];
  assign holdover_pin = pix[8];
endmodule
`default_nettype wire

// ===== bench/sync_clamp_holdover_control_test.sv
// Self-checking testbench of the sync, clamp and holdover control slice.
`default_nettype none
module sync_clamp_holdover_control_test;
  import schc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic lpin, fpin, gpin, cpin, hpin;
  logic line_en, frame_en, green_en, line_high;
  schc_sync_out_t sync_out;
  schc_oe_t out_en;
  schc_analog_cfg_t analog_cfg;
  logic chip_sleep_n;
  int fails = 0;
  int comparisons = 0;
  localparam logic [7:0] POR [9] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h4A, 8'h78, 8'h20,
    8'h00, 8'h00};
  schc_top #(.ACT_TICKS(50)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_sync_pin(lpin), .frame_sync_pin(fpin),
    .green_embedded_sync_input(gpin), .clamp_pin(cpin), .holdover_pin(hpin),
    .sync_out(sync_out), .out_en(out_en), .analog_cfg(analog_cfg),
    .chip_sleep_n(chip_sleep_n));
  schc_video_src i_src (.clk_sys(clk_sys), .line_en(line_en), .frame_en(frame_en),
    .green_en(green_en), .line_high(line_high), .line_sync_pin(lpin),
    .frame_sync_pin(fpin), .green_embedded_sync_input(gpin), .clamp_pin(cpin),
    .holdover_pin(hpin));
  // ****************************************************************
  // Bus cycles and checks
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_regs;
    logic [7:0] d;
    for (int i = 0; i < 9; i++)
    begin
      rd(8'h0B + 8'(i), d);
      check(d, POR[i]);
      wr(8'h0B + 8'(i), 8'h5A ^ 8'(i * 19));
    end
    rd(8'h20, d);
    check(d, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      rd(8'h0B + 8'(i), d);
      check(d, 8'h5A ^ 8'(i * 19));
      wr(8'h0B + 8'(i), POR[i]);
    end
    wr(ADDR_SEP_THRESH, 8'h02);
  endtask
  task automatic t_trim;
    logic [7:0] code [3] = '{8'h22, 8'h20, 8'h1E};
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_RED_TRIM, code[i]);
      idle(3);
      check({1'b0, analog_cfg.red_trim}, code[i] >> 1);
      check({7'h00, analog_cfg.darken[2]}, {7'h00, i == 0});
    end
    wr(ADDR_SLICER, 8'hFF);
    idle(3);
    check({3'h0, analog_cfg.slicer_code}, 8'h1F);
    wr(ADDR_SLICER, 8'h07);
    idle(3);
    check({3'h0, analog_cfg.slicer_code}, 8'h00);
  endtask
  task automatic t_status;
    logic [7:0] d;
    green_en <= 1'b1;
    idle(1400);
    rd(ADDR_SYNC_STATUS, d);
    check(d & 8'hDA, 8'h4A);
    line_en <= 1'b1;
    frame_en <= 1'b1;
    idle(1200);
    rd(ADDR_SYNC_STATUS, d);
    check(d & 8'hDA, 8'h92);
  endtask
  task automatic t_sep;
    int h;
    int m;
    wr(ADDR_SYNC_CTRL, 8'h07);
    wr(ADDR_CLAMP_CTRL, 8'h6A);
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_TRAIL_LINES, 8'(k * 2));
      h = 0;
      m = 0;
      repeat (1100)
      begin
        idle(1);
        h += sync_out.frame_sync_output;
        m += (sync_out.holdover_active != sync_out.frame_sync_output);
      end
      check({7'h00, h > 0 && h < 1100}, 8'h01);
      check({7'h00, m > 0}, {7'h00, k == 1});
    end
  endtask
  task automatic t_forced;
    logic [7:0] sv [4] = '{8'hD2, 8'h96, 8'hF6, 8'hB2};
    logic [7:0] cv [4] = '{8'hC2, 8'h82, 8'h1A, 8'h12};
    {line_en, frame_en, line_high} <= 3'b001;
    wr(ADDR_SYNC_CTRL, 8'hD2);
    idle(3);
    check({6'h00, sync_out.line_sync_output, sync_out.frame_sync_output}, 8'h01);
    wr(ADDR_SYNC_CTRL, 8'hF6);
    idle(3);
    check({6'h00, sync_out.line_sync_output, sync_out.frame_sync_output}, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      {line_en, frame_en, line_high} <= {2'b11, sv[i][6]};
      wr(ADDR_SYNC_CTRL, sv[i]);
      wr(ADDR_CLAMP_CTRL, cv[i]);
      idle(600);
    end
    wr(ADDR_CLAMP_CTRL, 8'h4A);
  endtask
  task automatic t_power;
    int n;
    logic prev;
    {line_en, frame_en, green_en} <= 3'b000;
    wr(ADDR_CLAMP_CTRL, 8'h4E);
    idle(1400);
    check({4'h0, chip_sleep_n, out_en}, 8'h08);
    green_en <= 1'b1;
    idle(80);
    check({5'h00, out_en}, 8'h07);
    wr(ADDR_CLAMP_CTRL, 8'h48);
    idle(3);
    check({4'h0, chip_sleep_n, out_en}, 8'h00);
    n = 0;
    prev = sync_out.slicer_sync_output;
    repeat (300)
    begin
      idle(1);
      n += (sync_out.slicer_sync_output !== prev);
      prev = sync_out.slicer_sync_output;
    end
    check({7'h00, n > 1}, 8'h01);
  endtask
  task automatic give_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    {line_en, frame_en, green_en, line_high} = 4'h1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_trim;
    t_status;
    t_sep;
    t_forced;
    t_power;
    give_verdict;
  end
  // Whole run is about 9100 cycles; the limit leaves ample margin.
  initial
  begin
    #300000;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== hdl/schc_pkg.sv
// Constants, register map and carrier types of the sync, clamp and holdover control slice.
`default_nettype none
package schc_pkg;

  // ****************************************************************
  // Register bus and map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_RED_TRIM = 8'h0B;
  localparam logic [7:0] ADDR_GREEN_TRIM = 8'h0C;
  localparam logic [7:0] ADDR_BLUE_TRIM = 8'h0D;
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h0E;
  localparam logic [7:0] ADDR_CLAMP_CTRL = 8'h0F;
  localparam logic [7:0] ADDR_SLICER = 8'h10;
  localparam logic [7:0] ADDR_SEP_THRESH = 8'h11;
  localparam logic [7:0] ADDR_LEAD_LINES = 8'h12;
  localparam logic [7:0] ADDR_TRAIL_LINES = 8'h13;
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h14;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] RST_TRIM = 8'h80;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h40;
  localparam logic [7:0] RST_CLAMP_CTRL = 8'h4A;
  localparam logic [7:0] RST_SLICER = 8'h78;
  localparam logic [7:0] RST_SEP_THRESH = 8'h20;
  localparam logic [7:0] RST_LEAD_LINES = 8'h00;
  localparam logic [7:0] RST_TRAIL_LINES = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TRIM_MSB = 7;
  localparam int TRIM_LSB = 1;
  localparam logic [6:0] TRIM_NEUTRAL = 7'h10;
  localparam int SC_LPOL_OVR = 7;
  localparam int SC_LPOL_IN = 6;
  localparam int SC_LPOL_OUT = 5;
  localparam int SC_LSRC_OVR = 4;
  localparam int SC_LSRC_SEL = 3;
  localparam int SC_FOUT_NOINV = 2;
  localparam int SC_FSRC_OVR = 1;
  localparam int SC_FSRC_SEL = 0;
  localparam int CC_CLAMP_EXT = 7;
  localparam int CC_CLAMP_LOW = 6;
  localparam int CC_HOLD_FRAME = 5;
  localparam int CC_HPOL_OVR = 4;
  localparam int CC_HPOL_HIGH = 3;
  localparam int CC_SEEK_EN = 2;
  localparam int CC_RUN = 1;
  localparam int SL_CODE_MSB = 7;
  localparam int SL_CODE_LSB = 3;
  localparam int SL_RED_MID = 2;
  localparam int SL_BLUE_MID = 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int SEP_CLK_HZ = 5_000_000;
  localparam int TICK_DIV = SYS_CLK_HZ / SEP_CLK_HZ;
  localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);
  localparam logic [7:0] INT_CLAMP_CYCLES = 8'h14;
  localparam int ACT_TICKS_DEFAULT = 100000;
  localparam logic [15:0] POL_MID = 16'h8000;

  // Input index inside the per-input monitor.
  localparam int IN_LINE = 0;
  localparam int IN_FRAME = 1;
  localparam int IN_HOLD = 2;
  localparam int IN_SLICER = 3;
  localparam int N_IN = 4;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [6:0] red_trim;
    logic [6:0] green_trim;
    logic [6:0] blue_trim;
    logic [2:0] darken;
    logic [4:0] slicer_code;
    logic red_clamp_mid;
    logic blue_clamp_mid;
  } schc_analog_cfg_t;

  typedef struct packed {
    logic line_sync_output;
    logic frame_sync_output;
    logic clamp_active;
    logic holdover_active;
    logic slicer_sync_output;
  } schc_sync_out_t;

  typedef struct packed {
    logic sync_oe;
    logic clock_oe;
    logic data_oe;
  } schc_oe_t;

endpackage
`default_nettype wire

// ===== hdl/schc_top.sv
// Register slice and sync, clamp and holdover control logic of the video front end.
//
// Functional notes
// - Offset trim is bits 7:1; above 10h darkens, below brightens.
// - Line-sync input polarity is detected unless override bit 7 forces bit 6.
// - Forced line-sync input polarity: 0 active low, 1 active high.
// - Line-sync output bit 5: 0 gives high pulse, 1 gives low pulse.
// - Line-sync source follows bit 3 when bit 4 set, else automatic choice.
// - Bit 3 picks pin or slicer; used under override or both active.
// - Frame-sync output bit 2: 0 inverts, 1 passes through.
// - Frame-sync source follows bit 0 when bit 1 set, else automatic.
// - Bit 0 picks frame pin or separator output, only under override.
// - Clamp bit 7: 0 internal line-sync timing, 1 external clamp pin.
// - Clamp pin polarity bit 6: 0 active high, 1 active low.
// - Holdover source bit 5: 0 holdover pin, 1 frame sync.
// - Holdover polarity detected unless bit 4; bit 3 then forces it.
// - Seek bit 2 with idle sync inputs tri-states sync, clock, data outputs.
// - Run bit 1 low powers down: same outputs tri-stated, sync stays alive.
// - Slicer threshold code bits 7:3, 10 mV steps from 10 mV.
// - Separator counts 5 MHz periods to threshold before toggling.
// - Lead register sets lines of holdover before frame sync.
// - Trail register sets lines of holdover after frame sync ends.
// - Status bit 6 reports automatic line-sync source choice.
// - Status bit 3 reports automatic frame-sync source choice.
`default_nettype none
module schc_top #(
  parameter int ACT_TICKS = schc_pkg::ACT_TICKS_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [schc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [schc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [schc_pkg::DATA_W-1:0] reg_rdata,
  // Sync and control inputs
  input wire logic line_sync_pin,
  input wire logic frame_sync_pin,
  input wire logic green_embedded_sync_input,
  input wire logic clamp_pin,
  input wire logic holdover_pin,
  // Outputs
  output schc_pkg::schc_sync_out_t sync_out,
  output schc_pkg::schc_oe_t out_en,
  output schc_pkg::schc_analog_cfg_t analog_cfg,
  output logic chip_sleep_n
);
  import schc_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] red_dc_offset_trim;
  logic [7:0] green_dc_offset_trim;
  logic [7:0] blue_dc_offset_trim;
  logic [7:0] sync_source_polarity_ctrl;
  logic [7:0] clamp_holdover_power_ctrl;
  logic [7:0] slicer_threshold_clamp_ref;
  logic [7:0] separator_count_threshold;
  logic [7:0] holdover_lead_lines;
  logic [7:0] holdover_trail_lines;
  logic [7:0] sync_status;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      red_dc_offset_trim <= RST_TRIM;
      green_dc_offset_trim <= RST_TRIM;
      blue_dc_offset_trim <= RST_TRIM;
      sync_source_polarity_ctrl <= RST_SYNC_CTRL;
      clamp_holdover_power_ctrl <= RST_CLAMP_CTRL;
      slicer_threshold_clamp_ref <= RST_SLICER;
      separator_count_threshold <= RST_SEP_THRESH;
      holdover_lead_lines <= RST_LEAD_LINES;
      holdover_trail_lines <= RST_TRAIL_LINES;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_RED_TRIM: red_dc_offset_trim <= reg_wdata;
        ADDR_GREEN_TRIM: green_dc_offset_trim <= reg_wdata;
        ADDR_BLUE_TRIM: blue_dc_offset_trim <= reg_wdata;
        ADDR_SYNC_CTRL: sync_source_polarity_ctrl <= reg_wdata;
        ADDR_CLAMP_CTRL: clamp_holdover_power_ctrl <= reg_wdata;
        ADDR_SLICER: slicer_threshold_clamp_ref <= reg_wdata;
        ADDR_SEP_THRESH: separator_count_threshold <= reg_wdata;
        ADDR_LEAD_LINES: holdover_lead_lines <= reg_wdata;
        ADDR_TRAIL_LINES: holdover_trail_lines <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unused low bits of the trim and slicer registers read back as written.
  wire logic [7:0] next_rdata;
  assign next_rdata = !reg_rd ? 8'h00 :
    (reg_addr == ADDR_RED_TRIM) ? red_dc_offset_trim :
    (reg_addr == ADDR_GREEN_TRIM) ? green_dc_offset_trim :
    (reg_addr == ADDR_BLUE_TRIM) ? blue_dc_offset_trim :
    (reg_addr == ADDR_SYNC_CTRL) ? sync_source_polarity_ctrl :
    (reg_addr == ADDR_CLAMP_CTRL) ? clamp_holdover_power_ctrl :
    (reg_addr == ADDR_SLICER) ? slicer_threshold_clamp_ref :
    (reg_addr == ADDR_SEP_THRESH) ? separator_count_threshold :
    (reg_addr == ADDR_LEAD_LINES) ? holdover_lead_lines :
    (reg_addr == ADDR_TRAIL_LINES) ? holdover_trail_lines :
    (reg_addr == ADDR_SYNC_STATUS) ? sync_status : READ_UNMAPPED;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  // ****************************************************************
  // Separator time base
  // ****************************************************************
  logic [4:0] tick_cnt;
  wire logic tick;
  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || tick)
      tick_cnt <= 5'h00;
    else
      tick_cnt <= tick_cnt + 5'h01;
  end

  // ****************************************************************
  // Input monitors: activity and polarity per input
  // ****************************************************************
  // Polarity is judged by which level dominates: a sync pulse is the short
  // level, so a mostly high input carries active low pulses.
  wire logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] in_q;
  logic [N_IN-1:0] in_act;
  logic [N_IN-1:0] in_pol_high;
  assign raw_in = {green_embedded_sync_input, holdover_pin, frame_sync_pin, line_sync_pin};

  // Loaded during reset as well, so a pin resting high gives no false edge after it.
  always_ff @(posedge clk_sys)
  begin
    in_q <= raw_in;
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_mon
      logic [16:0] idle_cnt;
      logic [15:0] balance;
      wire logic edge_seen;
      assign edge_seen = raw_in[gi] ^ in_q[gi];
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          idle_cnt <= 17'h00000;
          in_act[gi] <= 1'b0;
          balance <= POL_MID;
        end
        else
        begin
          if (edge_seen)
          begin
            idle_cnt <= 17'h00000;
            in_act[gi] <= 1'b1;
          end
          else if (tick && idle_cnt != 17'(ACT_TICKS))
            idle_cnt <= idle_cnt + 17'h00001;
          else if (idle_cnt == 17'(ACT_TICKS))
            in_act[gi] <= 1'b0;
          if (tick && in_q[gi] && balance != 16'hFFFF)
            balance <= balance + 16'h0001;
          else if (tick && !in_q[gi] && balance != 16'h0000)
            balance <= balance - 16'h0001;
        end
      end
      assign in_pol_high[gi] = (balance < POL_MID);
    end
  endgenerate

  // ****************************************************************
  // Sync separator
  // ****************************************************************
  // The composite sync on green is active low; a low level held past the
  // threshold marks the frame sync, so line pulses narrower than it are ignored.
  logic [7:0] sep_cnt;
  logic sep_out;
  wire logic sog_low;
  assign sog_low = ~in_q[IN_SLICER];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sep_cnt <= 8'h00;
      sep_out <= 1'b0;
    end
    else if (sog_low == sep_out)
      sep_cnt <= 8'h00;
    else if (sep_cnt >= separator_count_threshold)
    begin
      sep_out <= sog_low;
      sep_cnt <= 8'h00;
    end
    else if (tick)
      sep_cnt <= sep_cnt + 8'h01;
  end

  // ****************************************************************
  // Source and polarity selection
  // ****************************************************************
  wire logic line_act;
  wire logic frame_act;
  wire logic slicer_act;
  wire logic auto_line_sync_choice;
  wire logic auto_frame_sync_choice;
  wire logic line_sel;
  wire logic frame_sel;
  wire logic line_pol_high;
  wire logic line_norm;
  wire logic frame_norm;
  assign line_act = in_act[IN_LINE];
  assign frame_act = in_act[IN_FRAME];
  assign slicer_act = in_act[IN_SLICER];
  assign auto_line_sync_choice = (slicer_act && !line_act) ||
    (slicer_act && line_act && sync_source_polarity_ctrl[SC_LSRC_SEL]);
  assign auto_frame_sync_choice = slicer_act && !frame_act;
  assign line_sel = sync_source_polarity_ctrl[SC_LSRC_OVR] ?
    sync_source_polarity_ctrl[SC_LSRC_SEL] : auto_line_sync_choice;
  assign frame_sel = sync_source_polarity_ctrl[SC_FSRC_OVR] ?
    sync_source_polarity_ctrl[SC_FSRC_SEL] : auto_frame_sync_choice;
  assign line_pol_high = sync_source_polarity_ctrl[SC_LPOL_OVR] ?
    sync_source_polarity_ctrl[SC_LPOL_IN] : in_pol_high[IN_LINE];
  assign line_norm = line_sel ? sog_low : (in_q[IN_LINE] ~^ line_pol_high);
  assign frame_norm = frame_sel ? sep_out : (in_q[IN_FRAME] ~^ in_pol_high[IN_FRAME]);

  logic line_d;
  logic frame_d;
  wire logic line_lead;
  wire logic line_trail;
  wire logic frame_lead;
  wire logic frame_trail;
  assign line_lead = line_norm && !line_d;
  assign line_trail = !line_norm && line_d;
  assign frame_lead = frame_norm && !frame_d;
  assign frame_trail = !frame_norm && frame_d;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      line_d <= 1'b0;
      frame_d <= 1'b0;
    end
    else
    begin
      line_d <= line_norm;
      frame_d <= frame_norm;
    end
  end

  // ****************************************************************
  // Black-level clamp
  // ****************************************************************
  logic [7:0] clamp_cnt;
  wire logic clamp_next;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      clamp_cnt <= 8'h00;
    else if (line_trail)
      clamp_cnt <= INT_CLAMP_CYCLES;
    else if (clamp_cnt != 8'h00)
      clamp_cnt <= clamp_cnt - 8'h01;
  end

  assign clamp_next = clamp_holdover_power_ctrl[CC_CLAMP_EXT] ?
    (clamp_pin ^ clamp_holdover_power_ctrl[CC_CLAMP_LOW]) :
    (clamp_cnt != 8'h00);

  // ****************************************************************
  // PLL holdover
  // ****************************************************************
  // The lead window is predicted from the length of the previous frame, so
  // it is only right once one whole frame of stable timing has been seen.
  logic [11:0] line_cnt;
  logic [11:0] frame_len;
  logic [7:0] trail_cnt;
  wire logic lead_zone;
  wire logic hold_pol_high;
  wire logic hold_from_pin;
  wire logic hold_from_frame;
  wire logic hold_next;
  assign lead_zone = (holdover_lead_lines != 8'h00) &&
    ((line_cnt + {4'h0, holdover_lead_lines}) >= frame_len);
  assign hold_pol_high = clamp_holdover_power_ctrl[CC_HPOL_OVR] ?
    clamp_holdover_power_ctrl[CC_HPOL_HIGH] : in_pol_high[IN_HOLD];
  assign hold_from_pin = in_q[IN_HOLD] ~^ hold_pol_high;
  assign hold_from_frame = frame_norm || lead_zone || (trail_cnt != 8'h00);
  assign hold_next = clamp_holdover_power_ctrl[CC_HOLD_FRAME] ?
    hold_from_frame : hold_from_pin;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      line_cnt <= 12'h000;
      frame_len <= 12'hFFF;
      trail_cnt <= 8'h00;
    end
    else
    begin
      if (frame_lead)
      begin
        frame_len <= line_cnt;
        line_cnt <= 12'h000;
      end
      else if (line_lead && line_cnt != 12'hFFF)
        line_cnt <= line_cnt + 12'h001;
      if (frame_trail)
        trail_cnt <= holdover_trail_lines;
      else if (frame_lead)
        trail_cnt <= 8'h00;
      else if (line_lead && trail_cnt != 8'h00)
        trail_cnt <= trail_cnt - 8'h01;
    end
  end

  // ****************************************************************
  // Power state and outputs
  // ****************************************************************
  wire logic seek_idle;
  wire logic sleep_next;
  assign seek_idle = clamp_holdover_power_ctrl[CC_SEEK_EN] &&
    !line_act && !frame_act && !slicer_act;
  assign sleep_next = !clamp_holdover_power_ctrl[CC_RUN] || seek_idle;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync_out <= '0;
      out_en <= '0;
      analog_cfg <= '0;
      chip_sleep_n <= 1'b0;
    end
    else
    begin
      sync_out.line_sync_output <= line_norm ^ sync_source_polarity_ctrl[SC_LPOL_OUT];
      sync_out.frame_sync_output <= frame_norm ^ ~sync_source_polarity_ctrl[SC_FOUT_NOINV];
      sync_out.clamp_active <= clamp_next;
      sync_out.holdover_active <= hold_next;
      sync_out.slicer_sync_output <= in_q[IN_SLICER];
      out_en.sync_oe <= !sleep_next;
      out_en.clock_oe <= !sleep_next;
      out_en.data_oe <= !sleep_next;
      chip_sleep_n <= clamp_holdover_power_ctrl[CC_RUN];
      analog_cfg.red_trim <= red_dc_offset_trim[TRIM_MSB:TRIM_LSB];
      analog_cfg.green_trim <= green_dc_offset_trim[TRIM_MSB:TRIM_LSB];
      analog_cfg.blue_trim <= blue_dc_offset_trim[TRIM_MSB:TRIM_LSB];
      analog_cfg.darken <= {red_dc_offset_trim[TRIM_MSB:TRIM_LSB] > TRIM_NEUTRAL,
        green_dc_offset_trim[TRIM_MSB:TRIM_LSB] > TRIM_NEUTRAL,
        blue_dc_offset_trim[TRIM_MSB:TRIM_LSB] > TRIM_NEUTRAL};
      analog_cfg.slicer_code <= slicer_threshold_clamp_ref[SL_CODE_MSB:SL_CODE_LSB];
      analog_cfg.red_clamp_mid <= slicer_threshold_clamp_ref[SL_RED_MID];
      analog_cfg.blue_clamp_mid <= slicer_threshold_clamp_ref[SL_BLUE_MID];
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sync_status <= 8'h00;
    else
      sync_status <= {line_act, auto_line_sync_choice, in_pol_high[IN_LINE], frame_act,
        auto_frame_sync_choice, ~sync_source_polarity_ctrl[SC_FOUT_NOINV], slicer_act,
        hold_pol_high};
  end

endmodule
`default_nettype wire
